// ---- rtl/gpio_strap_map.vh ----
// constants for the general-purpose, strap and debug pin block
// assumes an 8-bit byte address space with 32-bit data
`ifndef GPIO_STRAP_MAP_VH
`define GPIO_STRAP_MAP_VH

// register byte offsets
`define GS_ADDR_GPIO_OE     8'h00
`define GS_ADDR_GPIO_OUT    8'h04
`define GS_ADDR_GPIO_IN     8'h08
`define GS_ADDR_STATUS      8'h0C
`define GS_ADDR_EEPROM      8'h10

// reset values
`define GS_RST_GPIO_OE      8'h00
`define GS_RST_GPIO_OUT     8'h00
`define GS_RST_EEPROM       3'h0

// status field positions
`define GS_ST_PWR_SAVE      0
`define GS_ST_DEBUG         1
`define GS_ST_SMB_LSB       2
`define GS_ST_SMB_MSB       4
`define GS_ST_SEL_LSB       5
`define GS_ST_SEL_MSB       9
`define GS_ST_SCAN_TEST     10

// eeprom control field positions
`define GS_EE_CLK           0
`define GS_EE_DOUT          1
`define GS_EE_DRIVE         2
`define GS_EE_DIN           3

// clock edges during which the power-saving strap is captured after reset
`define GS_STRAP_CYCLES     2'h3

`endif

// ---- rtl/pin_sync2.v ----
// two-stage synchroniser for a group of pin inputs
// assumes the inputs are independent levels; no bus coherence is kept
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

`default_nettype wire

// ---- rtl/gpio_strap_debug_pins.v ----
// general-purpose, strap, debug, scan, eeprom and smbus pin logic
// assumes: pins are external and asynchronous, core inputs share clk,
// board pull-ups hold open-drain and released lines high
//
// How it works
// R1 - each of eight gpio pins is input-only or bidirectional per enable bit
// R2 - with smbus in use, gpio 7..5 give the low three slave address bits
// R3 - in debug mode gpio 4..0 select the presented debug function
// R4 - power-saving strap caught around reset: high enables, low disables
// R5 - debug-mode strap low means debug mode, high means normal operation
// R6 - in debug mode port status pins drive only when their enable allows
// R7 - port status pins carry one status per port 0 to 2, by index
// R8 - scan enable pin drives zero normally, becomes input in factory test
// R9 - eeprom clock on its own output, data on a separate two-way pin
// R10 - eeprom data pin shows one whenever the block is not driving data
// R11 - smbus clock is input only; smbus data is driven low and sampled
// R12 - gpio output enables clear to zero at reset, all pins inputs
`timescale 1ns/1ps
`default_nettype none
`include "gpio_strap_map.vh"

module gpio_strap_debug_pins (
    input  wire        clk,
    input  wire        arst_n,
    // register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output wire [31:0] rdata,
    // general-purpose pins
    input  wire [7:0]  gpio_in,
    output wire [7:0]  gpio_out,
    output wire [7:0]  gpio_oe,
    // core-side configuration and results
    input  wire        smbus_enable,
    output wire [2:0]  smbus_addr_low,
    output wire [4:0]  debug_select,
    output wire        debug_mode,
    output wire        power_saving_mode,
    // straps and test pins
    input  wire        power_saving_strap,
    input  wire        debug_mode_strap,
    input  wire        port_status_enable,
    // port status to the debug header
    input  wire [2:0]  port_status_in,
    output wire [2:0]  per_port_status_out,
    output wire [2:0]  per_port_status_oe,
    // full-scan enable pin
    input  wire        scan_test_mode,
    input  wire        scan_en_in,
    output wire        scan_en_out,
    output wire        scan_en_oe,
    output wire        scan_en_sampled,
    // serial eeprom
    output wire        eeprom_serial_clock,
    input  wire        eeprom_serial_io_in,
    output wire        eeprom_serial_io_out,
    output wire        eeprom_serial_io_oe,
    // smbus pins
    input  wire        smbus_clock_in,
    input  wire        smbus_data_io_in,
    output wire        smbus_data_io_out,
    output wire        smbus_data_io_oe,
    input  wire        smbus_data_pull,
    output wire        smbus_clock_sync,
    output wire        smbus_data_sync
);

    // synchronised pin levels
    wire [15:0] pins_async;
    wire [15:0] pins_sync;
    wire [7:0]  gpio_s;
    wire        pwr_s;
    wire        dbg_strap_s;
    wire        pse_s;
    wire        test_s;
    wire        scan_s;
    wire        ee_s;
    wire        smbus_clock_in_s;
    wire        smbdat_s;

    assign pins_async = {smbus_data_io_in, smbus_clock_in,
                         eeprom_serial_io_in, scan_en_in,
                         scan_test_mode, port_status_enable,
                         debug_mode_strap, power_saving_strap, gpio_in};

    pin_sync2 #(
        .W (16)
    ) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    assign gpio_s      = pins_sync[7:0];
    assign pwr_s       = pins_sync[8];
    assign dbg_strap_s = pins_sync[9];
    assign pse_s       = pins_sync[10];
    assign test_s      = pins_sync[11];
    assign scan_s      = pins_sync[12];
    assign ee_s        = pins_sync[13];
    assign smbus_clock_in_s    = pins_sync[14];
    assign smbdat_s    = pins_sync[15];

    // software registers
    reg  [7:0]  gpio_oe_r;
    reg  [7:0]  gpio_out_r;
    reg  [2:0]  eeprom_r;
    reg  [31:0] rdata_r;
    reg  [31:0] rdata_nxt;

    // strap and pin state
    reg  [1:0]  strap_cnt_r;
    reg         pwr_save_r;
    reg         debug_r;
    reg  [2:0]  smb_addr_r;
    reg  [4:0]  dbg_sel_r;
    reg  [2:0]  pst_out_r;
    reg  [2:0]  pst_oe_r;
    reg         smb_oe_r;
    reg         scan_oe_r;

    wire        wr_oe;
    wire        wr_out;
    wire        wr_ee;
    wire [31:0] status_word;

    assign wr_oe  = wr_en && (addr == `GS_ADDR_GPIO_OE);
    assign wr_out = wr_en && (addr == `GS_ADDR_GPIO_OUT);
    assign wr_ee  = wr_en && (addr == `GS_ADDR_EEPROM);

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gpio_oe_r  <= `GS_RST_GPIO_OE; // [R12]
            gpio_out_r <= `GS_RST_GPIO_OUT;
            eeprom_r   <= `GS_RST_EEPROM;
        end
        else
        begin
            if (wr_oe)
                gpio_oe_r <= wdata[7:0]; // [R1]
            if (wr_out)
                gpio_out_r <= wdata[7:0];
            if (wr_ee)
                eeprom_r <= wdata[`GS_EE_DRIVE:`GS_EE_CLK];
        end
    end

    // strap capture: the synchroniser has settled by the last counted edge,
    // so the mode holds the level seen at reset release
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_cnt_r <= 2'h0;
            pwr_save_r  <= 1'b0;
        end
        else if (strap_cnt_r != `GS_STRAP_CYCLES)
        begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            pwr_save_r  <= pwr_s; // [R4]
        end
    end

    // debug mode follows the strap level; a board change takes effect live.
    // the synchroniser resets to zero while the strap idles high, so the
    // strap is ignored until its level has crossed both flops
    wire        dbg_live;

    assign dbg_live = ~dbg_strap_s & strap_cnt_r[1];

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            debug_r   <= 1'b0;
            dbg_sel_r <= 5'h00;
        end
        else
        begin
            debug_r   <= dbg_live; // [R5]
            dbg_sel_r <= dbg_live ? gpio_s[4:0] : 5'h00; // [R3]
        end
    end

    // slave address bits read as zero while smbus is unused
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            smb_addr_r <= 3'h0;
            smb_oe_r   <= 1'b0;
        end
        else
        begin
            smb_addr_r <= smbus_enable ? gpio_s[7:5] : 3'h0; // [R2]
            smb_oe_r   <= smbus_data_pull; // [R11]
        end
    end

    // scan pin released during reset and while the factory test input is high
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            scan_oe_r <= 1'b0;
        else
            scan_oe_r <= ~test_s; // [R8]
    end

    // one status flop and one drive enable per port, indexed by port
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1)
        begin : g_port
            always @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    pst_out_r[p] <= 1'b0;
                    pst_oe_r[p]  <= 1'b0;
                end
                else
                begin
                    pst_out_r[p] <= port_status_in[p]; // [R7]
                    pst_oe_r[p]  <= dbg_live & pse_s; // [R6]
                end
            end
        end
    endgenerate

    assign status_word = {21'h000000,
                          test_s,
                          dbg_sel_r,
                          smb_addr_r,
                          debug_r,
                          pwr_save_r};

    // read data stand only in the cycle after the strobe; unmapped reads 0
    always @*
    begin
        rdata_nxt = 32'h00000000;
        if (rd_en)
        begin
            case (addr)
                `GS_ADDR_GPIO_OE:  rdata_nxt = {24'h000000, gpio_oe_r};
                `GS_ADDR_GPIO_OUT: rdata_nxt = {24'h000000, gpio_out_r};
                `GS_ADDR_GPIO_IN:  rdata_nxt = {24'h000000, gpio_s};
                `GS_ADDR_STATUS:   rdata_nxt = status_word;
                `GS_ADDR_EEPROM:   rdata_nxt = {28'h0000000, ee_s, eeprom_r};
                default:           rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= 32'h00000000;
        else
            rdata_r <= rdata_nxt;
    end

    assign rdata = rdata_r;

    // gpio pins: disabled bits are input-only
    assign gpio_out = gpio_out_r;
    assign gpio_oe  = gpio_oe_r; // [R1]

    assign smbus_addr_low    = smb_addr_r;
    assign debug_select      = dbg_sel_r;
    assign debug_mode        = debug_r;
    assign power_saving_mode = pwr_save_r;

    assign per_port_status_out = pst_out_r; // [R7]
    assign per_port_status_oe  = pst_oe_r; // [R6]

    // scan enable: drives zero unless in reset or the factory test input is high
    assign scan_en_out     = 1'b0; // [R8]
    assign scan_en_oe      = scan_oe_r; // [R8]
    assign scan_en_sampled = scan_s;

    // eeprom: bit-banged by software; idle level on the data pin is one
    assign eeprom_serial_clock  = eeprom_r[`GS_EE_CLK]; // [R9]
    assign eeprom_serial_io_oe  = eeprom_r[`GS_EE_DRIVE]; // [R9]
    assign eeprom_serial_io_out = eeprom_r[`GS_EE_DRIVE] ?
                                  eeprom_r[`GS_EE_DOUT] : 1'b1; // [R10]

    // smbus: never a clock source; data is open-drain low only
    assign smbus_data_io_out = 1'b0; // [R11]
    assign smbus_data_io_oe  = smb_oe_r; // [R11]
    assign smbus_clock_sync  = smbus_clock_in_s; // [R11]
    assign smbus_data_sync   = smbdat_s;

endmodule

`default_nettype wire

// ---- dv/gpio_strap_debug_pins_properties.sv ----
// checker for the gpio, strap and pin block
// assumes it is bound to the block's top module
`timescale 1ns/1ps
`default_nettype none
module gpio_strap_debug_pins_props (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [7:0] gpio_in,
    input wire logic       smbus_enable,
    input wire logic [2:0] smbus_addr_low,
    input wire logic       debug_mode_strap,
    input wire logic       port_status_enable,
    input wire logic [2:0] per_port_status_oe,
    input wire logic       debug_mode,
    input wire logic [4:0] debug_select,
    input wire logic       scan_test_mode,
    input wire logic       scan_en_out,
    input wire logic       scan_en_oe,
    input wire logic       eeprom_serial_io_oe,
    input wire logic       eeprom_serial_io_out,
    input wire logic       smbus_data_pull,
    input wire logic       smbus_data_io_oe,
    input wire logic       smbus_data_io_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // four cycles cover two sync flops plus the output register
    scan_drive_zero_a: assert property (!scan_en_out)
        else $error("scan pin not low");
    scan_oe_normal_a: assert property ((!scan_test_mode)[*4] |-> scan_en_oe)
        else $error("scan pin not driven");
    scan_oe_test_a: assert property (scan_test_mode[*4] |-> !scan_en_oe)
        else $error("scan pin driven in test");
    ee_idle_one_a: assert property (!eeprom_serial_io_oe |-> eeprom_serial_io_out)
        else $error("eeprom data idle not one");
    smb_open_drain_a: assert property ($past(arst_n) |-> !smbus_data_io_out
        && smbus_data_io_oe == $past(smbus_data_pull)) else $error("smbus data");
    status_oe_gate_a: assert property ((debug_mode_strap || !port_status_enable)[*4]
        |-> per_port_status_oe == 3'h0) else $error("port status driven");
    debug_off_a: assert property (debug_mode_strap[*4]
        |-> !debug_mode && debug_select == 5'h00) else $error("debug mode on");
    smb_addr_a: assert property ((smbus_enable && $stable(gpio_in))[*4]
        |-> smbus_addr_low == gpio_in[7:5]) else $error("smbus address");
    cover property (debug_mode && per_port_status_oe == 3'h7);
    cover property (eeprom_serial_io_oe && !eeprom_serial_io_out);
    cover property (smbus_data_io_oe);
endmodule
bind gpio_strap_debug_pins gpio_strap_debug_pins_props u_props (.*);
`default_nettype wire

// ---- dv/pin_partner.sv ----
// far side: serial eeprom and smbus host on the block's pins
// assumes board pull-ups on eeprom data and both smbus lines
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input  wire logic ee_pull_low,
    input  wire logic host_clk_low,
    input  wire logic host_data_low,
    input  wire logic eeprom_serial_io_out,
    input  wire logic eeprom_serial_io_oe,
    input  wire logic smbus_data_io_out,
    input  wire logic smbus_data_io_oe,
    output logic      eeprom_serial_io_in,
    output logic      smbus_clock_in,
    output logic      smbus_data_io_in
);
    // eeprom answers only while the block has released the line
    assign eeprom_serial_io_in = eeprom_serial_io_oe ? eeprom_serial_io_out
                                                     : !ee_pull_low;
    assign smbus_clock_in = !host_clk_low;
    assign smbus_data_io_in = !(host_data_low
                                || (smbus_data_io_oe && !smbus_data_io_out));
endmodule
`default_nettype wire

// ---- dv/gpio_strap_debug_pins_tb_top.sv ----
// testbench for the gpio, strap and pin block
// assumes block, checker and pin partner compiled before it
`timescale 1ns/1ps
`default_nettype none
module gpio_strap_debug_pins_tb_top;
    logic clk, arst_n, wr_en, rd_en, smbus_enable, smbus_data_pull;
    logic power_saving_strap, debug_mode_strap, port_status_enable;
    logic scan_test_mode, scan_en_in, ee_pull_low, host_clk_low, host_data_low;
    logic debug_mode, power_saving_mode, scan_en_out, scan_en_oe;
    logic scan_en_sampled, eeprom_serial_clock, eeprom_serial_io_in;
    logic eeprom_serial_io_out, eeprom_serial_io_oe, smbus_clock_in;
    logic smbus_data_io_in, smbus_data_io_out, smbus_data_io_oe;
    logic smbus_clock_sync, smbus_data_sync;
    logic [7:0]  addr, gpio_in, gpio_out, gpio_oe;
    logic [31:0] wdata, rdata;
    logic [2:0]  port_status_in, smbus_addr_low, per_port_status_out;
    logic [2:0]  per_port_status_oe;
    logic [4:0]  debug_select;
    int          mismatches, comparisons;
    typedef struct packed { logic rd; logic [7:0] a; logic [31:0] d; } row_t;
    row_t rows [10] = '{
        '{1'h0, 8'h00, 32'hFF}, '{1'h1, 8'h00, 32'hFF},
        '{1'h0, 8'h04, 32'h5A}, '{1'h1, 8'h04, 32'h5A},
        '{1'h0, 8'h08, 32'h77}, '{1'h1, 8'h08, 32'hB3},
        '{1'h0, 8'h14, 32'hFFFFFFFF}, '{1'h1, 8'h14, 32'h0},
        '{1'h0, 8'h10, 32'h7}, '{1'h1, 8'h10, 32'hF}};
    gpio_strap_debug_pins DUT (.*);
    pin_partner u_partner (.*);
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= !rd;
        rd_en <= rd;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(negedge clk);
        if (rd)
            chk("rdata", rdata, d);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #50000;
        mismatches++;
        end_sim();
    end
    initial
    begin
        {wr_en, rd_en, smbus_enable, smbus_data_pull, scan_test_mode} = '0;
        {scan_en_in, ee_pull_low, host_clk_low, host_data_low} = '0;
        {power_saving_strap, debug_mode_strap, port_status_enable} = 3'h6;
        addr = 8'h00;
        wdata = 32'h0;
        gpio_in = 8'hB3;
        port_status_in = 3'h5;
        arst_n = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("gpio_oe", gpio_oe, 32'h0);
        chk("ps_mode", power_saving_mode, 32'h1);
        chk("scan", {scan_en_oe, scan_en_out}, 32'h2);
        chk("ee_out", eeprom_serial_io_out, 32'h1);
        power_saving_strap <= 1'b0;
        $display("test reset done");
        foreach (rows[i])
            bus(rows[i].rd, rows[i].a, rows[i].d);
        chk("gpio_pins", {gpio_oe, gpio_out}, 32'hFF5A);
        $display("test register rows done");
        {debug_mode_strap, port_status_enable} <= 2'h1;
        repeat (5) @(posedge clk);
        #1;
        chk("dbg", {debug_mode, debug_select, per_port_status_oe}, 32'h19F);
        chk("pst", per_port_status_out, 32'h5);
        chk("ps_mode", power_saving_mode, 32'h1);
        port_status_enable <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("pst_oe", per_port_status_oe, 32'h0);
        {debug_mode_strap, scan_test_mode, smbus_enable} <= 3'h7;
        {smbus_data_pull, host_clk_low, scan_en_in} <= 3'h7;
        repeat (5) @(posedge clk);
        #1;
        chk("normal", {debug_mode, scan_en_oe, smbus_addr_low}, 32'h5);
        chk("smbus", {smbus_data_io_oe, smbus_clock_sync, smbus_data_sync}, 32'h4);
        chk("scan_in", scan_en_sampled, 32'h1);
        bus(1'h1, 8'h0C, 32'h415);
        $display("test debug and smbus done");
        ee_pull_low <= 1'b1;
        bus(1'h0, 8'h10, 32'h5);
        chk("ee", {eeprom_serial_clock, eeprom_serial_io_oe, eeprom_serial_io_out}, 32'h6);
        bus(1'h0, 8'h10, 32'h0);
        chk("ee_idle", {eeprom_serial_io_oe, eeprom_serial_io_out}, 32'h1);
        repeat (3) @(posedge clk);
        bus(1'h1, 8'h10, 32'h0);
        $display("test eeprom done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("ps_mode", power_saving_mode, 32'h0);
        chk("gpio_oe", gpio_oe, 32'h0);
        $display("test second reset done");
        end_sim();
    end
endmodule
`default_nettype wire
